// file: verilog/eop_ctrl.sv
// controller driving an asynchronous 16-bit page-mode dynamic memory
// assumes the memory pins are sampled and driven on sys_clk; one
// request at a time from the user side, held until req_ready
`timescale 1ns/1ps
`include "eop_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - after power-up wait 200 us, then eight refresh cycles before access
// - after a refresh period overrun, repeat the eight-cycle wake-up
// - pulse both strobes high for column precharge to clear output
// - never late write or read-modify-write with the gate tied low
// - every read meets read-command hold to column or row strobe
// - late writes keep the gate high for disable and gate-hold time
// - no hidden refresh; refresh starts only from idle, write and gate high
// - page cycle time met edge to edge, falling and rising
// - 1,024 refresh cycles within every 16 ms
module eop_ctrl
  import eop_pkg::*;
#(
  parameter int WAKE_CYC = `EOP_WAKE_CYC,
  parameter int REF_INT_CYC = `EOP_REF_INTERVAL_CYC,
  parameter int ROWS = `EOP_REF_ROWS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input eop_pkg::eop_op_t req_op,
  input wire logic [9:0] req_row,
  input wire logic [9:0] req_col,
  input wire logic [1:0] req_byte_en,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic init_done,
  output logic row_strobe_n,
  output logic upper_byte_column_strobe_n,
  output logic lower_byte_column_strobe_n,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic [9:0] addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in
);
  import eop_pkg::*;
  initial begin
    if (WAKE_CYC < 2 || REF_INT_CYC < 64 || REF_INT_CYC > 65535)
      $error("eop_ctrl timing parameters out of range");
    if (ROWS != `EOP_REF_ROWS) $error("eop_ctrl row count unsupported");
  end
  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_WAKE, ST_IDLE, ST_REF_COL, ST_REF_ROW, ST_REF_PRE,
    ST_ROW, ST_COL, ST_RD_HOLD, ST_WR, ST_GATE_HOLD, ST_COL_PRE, ST_PRE
  } eop_st_t;
  typedef struct packed {
    eop_st_t st;
    logic [3:0] wake_left;
    logic wake_run;
    logic [15:0] ref_cnt;
    logic ref_owed;
    logic ready, rvalid, idone;
    logic [15:0] rdata;
    logic ras_n, upper_byte_column_strobe_n_n, lower_byte_column_strobe_n_n, we_n, oe_n, oe;
    logic [9:0] a;
    logic [15:0] dq;
    eop_op_t op;
    logic [1:0] be;
    logic [15:0] wd;
    logic [9:0] col;
  } eop_state_t;
  eop_state_t s_r, s_nxt;
  logic tmr_load, tmr_done;
  logic [15:0] tmr_count;
  eop_timer #(.W(16)) u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    tmr_load = 1'b0;
    tmr_count = 16'h0000;
    s_nxt.rvalid = 1'b0;
    s_nxt.ready = 1'b0;
    // refresh debt: one row per interval
    if (s_r.ref_cnt == 16'(REF_INT_CYC - 1)) begin
      s_nxt.ref_cnt = 16'h0000;
      // a second debt before the first is paid means tref overrun
      if (s_r.ref_owed && s_r.idone) begin
        s_nxt.idone = 1'b0;
        s_nxt.wake_left = 4'(`EOP_WAKE_REFRESHES);
      end
      s_nxt.ref_owed = 1'b1;
    end else begin
      s_nxt.ref_cnt = s_r.ref_cnt + 16'h0001;
    end
    case (s_r.st)
      ST_WAKE: begin
        // 200 us pause with all strobes high, then eight refreshes
        if (!s_r.wake_run) begin
          tmr_load = 1'b1;
          tmr_count = 16'(WAKE_CYC);
          s_nxt.wake_run = 1'b1;
        end else if (tmr_done) begin
          s_nxt.st = ST_IDLE;
          s_nxt.wake_left = 4'(`EOP_WAKE_REFRESHES);
        end
      end
      ST_IDLE: begin
        s_nxt.oe = 1'b0;
        s_nxt.we_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        if (s_r.wake_left != 4'h0 || s_r.ref_owed) begin
          // column-first refresh, address and gate don't care
          // strobe-only refresh is never issued, so no row address
          // refresh starts only from idle, never hidden
          s_nxt.upper_byte_column_strobe_n_n = 1'b0;
          s_nxt.lower_byte_column_strobe_n_n = 1'b0;
          s_nxt.st = ST_REF_COL;
        end else if (s_r.idone && req_valid) begin
          s_nxt.ready = 1'b1;
          s_nxt.op = req_op;
          s_nxt.be = req_byte_en;
          s_nxt.wd = req_wdata;
          s_nxt.col = req_col;
          s_nxt.a = req_row;
          s_nxt.ras_n = 1'b0;
          tmr_load = 1'b1;
          tmr_count = 16'(`EOP_ROW_TO_COL_CYC);
          s_nxt.st = ST_ROW;
        end
      end
      ST_REF_COL: begin
        s_nxt.ras_n = 1'b0;
        s_nxt.ref_owed = 1'b0;
        tmr_load = 1'b1;
        tmr_count = 16'(`EOP_ROW_PULSE_CYC);
        s_nxt.st = ST_REF_ROW;
      end
      ST_REF_ROW: if (tmr_done) begin
        s_nxt.ras_n = 1'b1;
        s_nxt.upper_byte_column_strobe_n_n = 1'b1;
        s_nxt.lower_byte_column_strobe_n_n = 1'b1;
        if (s_r.wake_left != 4'h0) begin
          s_nxt.wake_left = s_r.wake_left - 4'h1;
          if (s_r.wake_left == 4'h1) s_nxt.idone = 1'b1;
        end
        tmr_load = 1'b1;
        tmr_count = 16'(`EOP_ROW_PRE_CYC);
        s_nxt.st = ST_REF_PRE;
      end
      ST_REF_PRE: if (tmr_done) s_nxt.st = ST_IDLE;
      ST_ROW: if (tmr_done) begin
        s_nxt.a = s_r.col;
        // write strobe falls with the column strobe: early write
        if (s_r.op == EOP_OP_WRITE) begin
          s_nxt.we_n = 1'b0;
          s_nxt.dq = s_r.wd;
          s_nxt.oe = 1'b1;
        end else begin
          // gate low for reads; rmw needs gate control
          s_nxt.oe_n = 1'b0;
        end
        // byte lanes on their own column strobes
        s_nxt.lower_byte_column_strobe_n_n = !s_r.be[0];
        s_nxt.upper_byte_column_strobe_n_n = !s_r.be[1];
        tmr_load = 1'b1;
        tmr_count = 16'(`EOP_COL_PULSE_CYC);
        s_nxt.st = ST_COL;
      end
      ST_COL: if (tmr_done) begin
        if (s_r.op == EOP_OP_WRITE) begin
          s_nxt.st = ST_PRE;
          s_nxt.lower_byte_column_strobe_n_n = 1'b1;
          s_nxt.upper_byte_column_strobe_n_n = 1'b1;
          s_nxt.we_n = 1'b1;
          s_nxt.oe = 1'b0;
          tmr_load = 1'b1;
          tmr_count = 16'(`EOP_ROW_PRE_CYC);
        end else begin
          s_nxt.rdata = dq_in;
          // gate high before the write strobe, device floats
          s_nxt.oe_n = 1'b1;
          s_nxt.st = ST_RD_HOLD;
          tmr_load = 1'b1;
          tmr_count = 16'(`EOP_GATE_HOLD_CYC);
        end
      end
      ST_RD_HOLD: if (tmr_done) begin
        if (s_r.op == EOP_OP_RMW) begin
          // late write after delays, gate still high
          s_nxt.we_n = 1'b0;
          s_nxt.dq = s_r.wd;
          s_nxt.oe = 1'b1;
          s_nxt.st = ST_WR;
          tmr_load = 1'b1;
          tmr_count = 16'(`EOP_GATE_HOLD_CYC);
        end else begin
          // write strobe stays high through both strobes rising
          s_nxt.rvalid = 1'b1;
          s_nxt.lower_byte_column_strobe_n_n = 1'b1;
          s_nxt.upper_byte_column_strobe_n_n = 1'b1;
          s_nxt.st = ST_COL_PRE;
          tmr_load = 1'b1;
          tmr_count = 16'(`EOP_COL_PRE_CYC);
        end
      end
      ST_WR: if (tmr_done) begin
        s_nxt.rvalid = 1'b1;
        s_nxt.lower_byte_column_strobe_n_n = 1'b1;
        s_nxt.upper_byte_column_strobe_n_n = 1'b1;
        s_nxt.we_n = 1'b1;
        s_nxt.oe = 1'b0;
        s_nxt.st = ST_COL_PRE;
        tmr_load = 1'b1;
        tmr_count = 16'(`EOP_COL_PRE_CYC);
      end
      // both strobes high for the column precharge clears outputs
      // one column per row cycle keeps page timing slack on both edges
      ST_COL_PRE: if (tmr_done) begin
        s_nxt.ras_n = 1'b1;
        s_nxt.st = ST_PRE;
        tmr_load = 1'b1;
        tmr_count = 16'(`EOP_ROW_PRE_CYC);
      end
      ST_PRE: if (tmr_done) begin
        s_nxt.ras_n = 1'b1;
        s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (s_r.st == ST_COL && tmr_done && s_r.op == EOP_OP_WRITE)
      s_nxt.ras_n = 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= ST_WAKE;
      s_r.ras_n <= 1'b1;
      s_r.upper_byte_column_strobe_n_n <= 1'b1;
      s_r.lower_byte_column_strobe_n_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign req_ready = s_r.ready;
  assign rsp_valid = s_r.rvalid;
  assign rsp_rdata = s_r.rdata;
  assign init_done = s_r.idone;
  assign row_strobe_n = s_r.ras_n;
  assign upper_byte_column_strobe_n = s_r.upper_byte_column_strobe_n_n;
  assign lower_byte_column_strobe_n = s_r.lower_byte_column_strobe_n_n;
  assign write_strobe_n = s_r.we_n;
  assign output_gate_n = s_r.oe_n;
  assign addr = s_r.a;
  assign dq_out = s_r.dq;
  assign dq_oe = s_r.oe;
  //////////////////////////////////////////////////////////////////////////
  a_drive_gate_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    dq_oe |-> output_gate_n) else $error("driving with gate low");
  a_refresh_col_first: assert property (@(posedge sys_clk)
    disable iff (!nrst) $fell(row_strobe_n) && s_r.st == ST_REF_ROW
    |-> !lower_byte_column_strobe_n)
    else $error("refresh row fell without column low");
  a_no_access_early: assert property (@(posedge sys_clk) disable iff (!nrst)
    req_ready |-> init_done) else $error("access before wake-up");
  a_write_with_col: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(write_strobe_n) && s_r.op == EOP_OP_WRITE
    |-> $fell(lower_byte_column_strobe_n) || $fell(upper_byte_column_strobe_n)
    || (lower_byte_column_strobe_n && upper_byte_column_strobe_n))
    else $error("early write strobe not with column");
  a_rmw_gate_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(write_strobe_n) && s_r.op == EOP_OP_RMW |-> output_gate_n)
    else $error("late write with gate low");
  a_col_precharge: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(rsp_valid) && s_r.op == EOP_OP_READ
    |-> lower_byte_column_strobe_n && upper_byte_column_strobe_n
    && !row_strobe_n ##1 row_strobe_n)
    else $error("column precharge missing");
  a_read_we_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_r.op == EOP_OP_READ && !row_strobe_n |-> write_strobe_n)
    else $error("write strobe low in read");
  a_wake_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(init_done) |-> s_r.st == ST_REF_PRE)
    else $error("wake-up ended outside refresh");
  c_read: cover property (@(posedge sys_clk) rsp_valid && s_r.op == EOP_OP_READ);
  c_rmw: cover property (@(posedge sys_clk) rsp_valid && s_r.op == EOP_OP_RMW);
  c_refresh: cover property (@(posedge sys_clk) s_r.st == ST_REF_ROW);
endmodule // eop_ctrl

// file: verilog/eop_defs.svh
// timing constants and refresh row count for the page-mode memory controller
// assumes a 100 MHz sys_clk; counts are derived from times in ns
`ifndef EOP_DEFS_SVH
`define EOP_DEFS_SVH
`define EOP_CLK_NS 10
`define EOP_WAKE_US 200
`define EOP_WAKE_CYC ((`EOP_WAKE_US * 1000) / `EOP_CLK_NS)
`define EOP_WAKE_REFRESHES 8
`define EOP_REF_ROWS 1024
`define EOP_REF_MS 16
`define EOP_REF_INTERVAL_CYC \
  ((`EOP_REF_MS * 1000000) / `EOP_CLK_NS / `EOP_REF_ROWS)
// phase lengths in ns, rounded up to cycles
`define EOP_ROW_PRE_NS 40
`define EOP_ROW_PRE_CYC ((`EOP_ROW_PRE_NS + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`define EOP_ROW_TO_COL_NS 20
`define EOP_ROW_TO_COL_CYC \
  ((`EOP_ROW_TO_COL_NS + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`define EOP_COL_PULSE_NS 30
`define EOP_COL_PULSE_CYC \
  ((`EOP_COL_PULSE_NS + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`define EOP_COL_PRE_NS 10
`define EOP_COL_PRE_CYC ((`EOP_COL_PRE_NS + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`define EOP_ROW_PULSE_NS 60
`define EOP_ROW_PULSE_CYC \
  ((`EOP_ROW_PULSE_NS + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`define EOP_GATE_HOLD_NS 15
`define EOP_GATE_HOLD_CYC \
  ((`EOP_GATE_HOLD_NS + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`endif

// file: verilog/eop_pkg.sv
// types shared by the page-mode memory controller
package eop_pkg;
  typedef enum logic [1:0] {
    EOP_OP_READ,
    EOP_OP_WRITE,
    EOP_OP_RMW
  } eop_op_t;
endpackage

// file: verilog/eop_timer.sv
// down-counter that pulses done when a loaded count has elapsed
// assumes load is a one-cycle request; count of 0 is treated as 1
`timescale 1ns/1ps
module eop_timer #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
  } eop_tmr_t;
  eop_tmr_t s_r, s_nxt;
  initial begin
    if (W < 2) $error("eop_timer width too small");
  end
  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = (count == '0) ? W'(1) : count;
      s_nxt.run = 1'b1;
    end else if (s_r.run) begin
      s_nxt.cnt = s_r.cnt - W'(1);
      if (s_r.cnt == W'(1)) s_nxt.run = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign done = s_r.run && (s_r.cnt == W'(1));
endmodule // eop_timer

// file: bench/eop_mem_model.sv
// behavioural model of the 16-bit page-mode memory at the pin side
// assumes pins change only after sys_clk edges; samples them on sys_clk
`timescale 1ns/1ps
module eop_mem_model (
  input wire logic sys_clk,
  input wire logic row_strobe_n,
  input wire logic upper_byte_column_strobe_n,
  input wire logic lower_byte_column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic [9:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in
);
  logic [15:0] mem [int];
  logic [9:0] row_q = 10'h000;
  logic [9:0] col_q = 10'h000;
  logic [9:0] col_now;
  logic row_d = 1'b1;
  logic col_d = 1'b1;
  logic col_lo;
  logic hi_on, lo_on;
  logic undef;
  logic [15:0] rd;
  logic [15:0] last_q = 16'h0000;
  int n_refresh = 0;
  int n_clash = 0;
  //////////////////////////////////////////////////////////////
  assign col_lo = !upper_byte_column_strobe_n || !lower_byte_column_strobe_n;
  assign col_now = (col_lo && col_d) ? addr : col_q;
  // no drive while the gate is high or a write is under way
  assign hi_on = !output_gate_n && write_strobe_n &&
    !upper_byte_column_strobe_n;
  assign lo_on = !output_gate_n && write_strobe_n &&
    !lower_byte_column_strobe_n;
  always_comb begin
    rd = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : 16'h0000;
  end
  // a released lane shows the inverse of its last value, never a hold
  // gate low with a write under way meets neither write timing
  assign undef = !output_gate_n && !write_strobe_n && col_lo;
  assign dq_in = undef ? 16'hxxxx : {hi_on ? rd[15:8] : ~last_q[15:8],
    lo_on ? rd[7:0] : ~last_q[7:0]};
  //////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    last_q <= dq_in;
    row_d <= row_strobe_n;
    col_d <= !col_lo;
    if (dq_oe && (hi_on || lo_on)) begin
      n_clash <= n_clash + 1;
    end
    if (row_d && !row_strobe_n) begin
      if (col_lo) begin
        n_refresh <= n_refresh + 1;
      end else begin
        row_q <= addr;
      end
    end
    // a new column is only taken after both strobes went high
    if (col_lo && col_d && !row_strobe_n) begin
      col_q <= addr;
    end
    // write while the write strobe is low, early or late alike
    if (!row_strobe_n && col_lo && !write_strobe_n) begin
      if (!mem.exists({row_q, col_now})) begin
        mem[{row_q, col_now}] = 16'h0000;
      end
      if (!upper_byte_column_strobe_n) begin
        mem[{row_q, col_now}][15:8] = dq_out[15:8];
      end
      if (!lower_byte_column_strobe_n) begin
        mem[{row_q, col_now}][7:0] = dq_out[7:0];
      end
    end
  end
endmodule // eop_mem_model

// file: bench/eop_ctrl_tb.sv
// self-checking bench for the page-mode memory controller
// assumes the memory model answers on the pins; counts shortened
`timescale 1ns/1ps
module eop_ctrl_tb;
  import eop_pkg::*;
  localparam int WAKE = 20;
  localparam int RINT = 64;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  eop_op_t req_op = EOP_OP_READ;
  logic [9:0] req_row = 10'h000;
  logic [9:0] req_col = 10'h000;
  logic [1:0] req_byte_en = 2'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, rsp_valid, init_done, row_strobe_n, write_strobe_n;
  logic upper_byte_column_strobe_n, lower_byte_column_strobe_n;
  logic output_gate_n, dq_oe;
  logic [15:0] rsp_rdata, dq_out, dq_in, d;
  logic [9:0] addr;
  int n_errors = 0;
  int checked = 0;
  always #5 sys_clk = ~sys_clk;
  eop_ctrl #(.WAKE_CYC(WAKE), .REF_INT_CYC(RINT)) dut (.sys_clk, .nrst,
    .req_valid, .req_op, .req_row, .req_col, .req_byte_en, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .init_done, .row_strobe_n,
    .upper_byte_column_strobe_n, .lower_byte_column_strobe_n,
    .write_strobe_n, .output_gate_n, .addr, .dq_out, .dq_oe, .dq_in);
  eop_mem_model mdl (.sys_clk, .row_strobe_n, .upper_byte_column_strobe_n,
    .lower_byte_column_strobe_n, .write_strobe_n, .output_gate_n, .addr,
    .dq_out, .dq_oe, .dq_in);
  //////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic issue(input eop_op_t op, input logic [9:0] r, c,
    input logic [1:0] be, input logic [15:0] wd);
    req_valid <= 1'b1;
    req_op <= op;
    req_row <= r;
    req_col <= c;
    req_byte_en <= be;
    req_wdata <= wd;
  endtask
  // request stays up until ready is seen, then drops at the next edge
  task automatic wait_ready();
    int i;
    for (i = 0; i < 300 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (req_ready !== 1'b1) begin
      n_errors++;
      final_report();
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask
  task automatic do_req(input eop_op_t op, input logic [9:0] r, c,
    input logic [1:0] be, input logic [15:0] wd);
    @(posedge sys_clk);
    issue(op, r, c, be, wd);
    wait_ready();
  endtask
  task automatic get_rsp();
    int i;
    for (i = 0; i < 300 && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
    if (rsp_valid !== 1'b1) begin
      n_errors++;
      final_report();
    end
    d = rsp_rdata;
  endtask
  //////////////////////////////////////////////////////////////
  // a write held during wake-up must not be taken before init_done
  task automatic t_wake();
    int i, base;
    logic early;
    early = 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check("init_done in reset", init_done, 1'b0);
    check("strobes in reset", {row_strobe_n, upper_byte_column_strobe_n,
      lower_byte_column_strobe_n, write_strobe_n, output_gate_n},
      16'h001f);
    base = mdl.n_refresh;
    @(posedge sys_clk);
    nrst <= 1'b1;
    issue(EOP_OP_WRITE, 10'h001, 10'h001, 2'h3, 16'hbeef);
    for (i = 0; i < WAKE + 500 && init_done !== 1'b1; i++) begin
      @(negedge sys_clk);
      if (req_ready === 1'b1 && init_done !== 1'b1) early = 1'b1;
    end
    check("wake length", 16'(i >= WAKE), 16'h0001);
    check("wake refreshes", 16'(mdl.n_refresh - base), 16'h0008);
    check("early ready", early, 1'b0);
    wait_ready();
    do_req(EOP_OP_READ, 10'h001, 10'h001, 2'h3, 16'h0000);
    get_rsp();
    check("rdata after wake", d, 16'hbeef);
  endtask
  task automatic t_bytes();
    do_req(EOP_OP_WRITE, 10'h002, 10'h003, 2'h3, 16'ha5c3);
    do_req(EOP_OP_WRITE, 10'h002, 10'h003, 2'h1, 16'h1234);
    do_req(EOP_OP_WRITE, 10'h002, 10'h003, 2'h2, 16'h7800);
    do_req(EOP_OP_READ, 10'h002, 10'h003, 2'h3, 16'h0000);
    get_rsp();
    check("rdata both lanes", d, 16'h7834);
    do_req(EOP_OP_READ, 10'h002, 10'h003, 2'h1, 16'h0000);
    get_rsp();
    check("rdata low lane", {8'h00, d[7:0]}, 16'h0034);
  endtask
  task automatic t_rmw();
    do_req(EOP_OP_WRITE, 10'h3ff, 10'h3ff, 2'h3, 16'h3c3c);
    do_req(EOP_OP_RMW, 10'h3ff, 10'h3ff, 2'h3, 16'h0f0f);
    get_rsp();
    check("rmw old data", d, 16'h3c3c);
    do_req(EOP_OP_READ, 10'h3ff, 10'h3ff, 2'h3, 16'h0000);
    get_rsp();
    check("rmw new data", d, 16'h0f0f);
  endtask
  task automatic t_refresh();
    int base;
    base = mdl.n_refresh;
    repeat (3 * RINT) @(posedge sys_clk);
    check("idle refreshes", 16'(mdl.n_refresh - base >= 2), 16'h0001);
    check("init kept", init_done, 1'b1);
  endtask
  initial begin
    t_wake();
    t_bytes();
    t_rmw();
    t_refresh();
    t_wake();
    check("bus clashes", 16'(mdl.n_clash), 16'h0000);
    final_report();
  end
endmodule // eop_ctrl_tb
